// file: rtl/pcs_regs.vh
// Register offsets, field positions and reset values of the port C status block
`ifndef PCS_REGS_VH
`define PCS_REGS_VH
// Byte offsets on the register bus
`define PCS_OFS_MODE 5'h00
`define PCS_OFS_PORTC 5'h04
`define PCS_OFS_BITCMD 5'h08
`define PCS_OFS_IRQ_STATUS 5'h0c
`define PCS_OFS_IRQ_MASK 5'h10
`define PCS_OFS_PORTA_STROBE 5'h14
`define PCS_OFS_PORTB_STROBE 5'h18
// Mode word fields
`define PCS_MODE_A_LSB 0
`define PCS_MODE_A_MSB 1
`define PCS_MODE_A_DIR_IN 2
`define PCS_MODE_UPPER_IN 3
`define PCS_MODE_B 4
`define PCS_MODE_B_DIR_IN 5
`define PCS_MODE_LOWER_IN 6
`define PCS_MODE_WIDTH 7
`define PCS_MODE_RESET 7'h00
// Bit command fields
`define PCS_BITCMD_IDX_LSB 0
`define PCS_BITCMD_IDX_MSB 2
`define PCS_BITCMD_VALUE 3
// Port C positions of the handshake lines
`define PCS_PC_REQ_B 0
`define PCS_PC_FULL_B 1
`define PCS_PC_STROBE_B 2
`define PCS_PC_REQ_A 3
`define PCS_PC_STROBE_A_IN 4
`define PCS_PC_FULL_A_IN 5
`define PCS_PC_ACCEPT_A_OUT 6
`define PCS_PC_FULL_A_OUT 7
// Interrupt status bits, their width and reset value, and the port C reset value
`define PCS_IRQ_REQ_A 0
`define PCS_IRQ_REQ_B 1
`define PCS_IRQ_WIDTH 2
`define PCS_IRQ_RESET 2'h0
`define PCS_PORTC_RESET 8'h00
`endif

// file: rtl/pcs_handshake.v
// One strobed handshake channel: buffer full flag and service request
`default_nettype none
module pcs_handshake (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Configuration
   input wire enable,
   input wire dir_in,
   input wire irq_enable_flag,
   // Peripheral strobe or accept pin, active low
   input wire strobe_n,
   // Host data access of the matching port, one-cycle pulse
   input wire host_access,
   // Forcing from the single-bit command
   input wire force_full,
   input wire full_value,
   input wire force_req,
   input wire req_value,
   // Status
   output reg buffer_full,
   output reg service_request
);
   wire cond;

   // Output side raises the request once the peripheral has drained the buffer
   assign cond = dir_in ? (strobe_n & buffer_full & irq_enable_flag) :
                 (strobe_n & ~buffer_full & irq_enable_flag);

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         buffer_full <= 1'b0;
         service_request <= 1'b0;
      end else if (!enable) begin
         buffer_full <= 1'b0;
         service_request <= 1'b0;
      end else begin
         if (dir_in) begin
            // Strobe level wins over the read that would clear it
            if (!strobe_n)
               buffer_full <= 1'b1;
            else if (host_access)
               buffer_full <= 1'b0;
            else if (force_full)
               buffer_full <= full_value;
         end else begin
            if (host_access)
               buffer_full <= 1'b1;
            else if (!strobe_n)
               buffer_full <= 1'b0;
            else if (force_full)
               buffer_full <= full_value;
         end
         if (host_access)
            service_request <= 1'b0;
         else if (force_req)
            service_request <= req_value;
         else if (!irq_enable_flag)
            service_request <= 1'b0;
         else if (cond)
            service_request <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: rtl/pcs_irq_ctrl.v
// Sticky interrupt status with write-one-to-clear, mask and level output
`default_nettype none
module pcs_irq_ctrl #(
   parameter WIDTH = 2
) (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Events, one-cycle pulses
   input wire [WIDTH-1:0] event_pulse,
   // Register writes
   input wire status_write,
   input wire mask_write,
   input wire [WIDTH-1:0] write_data,
   // State
   output reg [WIDTH-1:0] status,
   output reg [WIDTH-1:0] mask,
   output wire irq
);
   wire [WIDTH-1:0] clear_bits;

   assign clear_bits = status_write ? write_data : {WIDTH{1'b0}};
   assign irq = |(status & mask);

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status <= {WIDTH{1'b0}};
         mask <= {WIDTH{1'b0}};
      end else begin
         // A new event beats a clear in the same cycle
         status <= (status & ~clear_bits) | event_pulse;
         if (mask_write)
            mask <= write_data;
      end
   end
endmodule
`default_nettype wire

// file: rtl/pcs_portc.v
// Port C access logic: mode-dependent pin roles, bit command and status read
//
// Summary of operation
// - Unclaimed port C lines are plain inputs/outputs.
// - Read returns pins, enable flags at 2/4/6.
// - Whole write changes only mode 0 outputs.
// - Whole write never touches enable flags.
// - Bit command drives any output line.
// - Bit command never alters input lines.
// - Bit command at strobe positions sets flags.
// - Mode 0 data, modes 1/2 handshake lines.
// - Status comes from an ordinary port C read.
// - Group B enable flag at bit 2.
// - Group A input enable flag at bit 4.
// - Group A output enable flag at bit 6.
// - Input full sets on strobe, clears on read.
// - Output full sets on write, clears on accept.
// - Output request on accept high, clears on write.
`include "pcs_regs.vh"
`default_nettype none
module pcs_portc (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Avalon-MM slave
   input wire [4:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   // Port C pins
   input wire [7:0] portc_in,
   output reg [7:0] portc_out,
   output reg [7:0] portc_oe_n,
   // Interrupt
   output wire irq
);
   // Group A pin role helpers, shared by the masks and the bit command
   function a_in_side;
      input [1:0] a_mode;
      input a_dir_in;
      begin
         a_in_side = a_mode[1] | (a_mode == 2'h1 && a_dir_in);
      end
   endfunction

   function a_out_side;
      input [1:0] a_mode;
      input a_dir_in;
      begin
         a_out_side = a_mode[1] | (a_mode == 2'h1 && !a_dir_in);
      end
   endfunction

   reg [`PCS_MODE_WIDTH-1:0] mode;
   reg [7:0] latch;
   reg group_b_irq_enable;
   reg group_a_in_irq_enable;
   reg group_a_out_irq_enable;
   reg ack;
   reg req_a_prev;
   reg req_b_prev;
   reg [7:0] hs_in_mask;
   reg [7:0] hs_out_mask;
   reg [7:0] hs_out_value;
   reg [7:0] next_portc_out;
   reg [31:0] next_readdata;
   wire [1:0] a_mode;
   wire a_dir_in;
   wire upper_in;
   wire b_mode;
   wire b_dir_in;
   wire lower_in;
   wire a_in_act;
   wire a_out_act;
   wire request;
   wire accept;
   wire lane0;
   wire wr_mode;
   wire wr_portc;
   wire wr_bitcmd;
   wire wr_status;
   wire wr_mask;
   wire acc_a;
   wire acc_b;
   wire [2:0] bit_idx;
   wire bit_val;
   wire [7:0] plain_mask;
   wire [7:0] out_dir_mask;
   wire [7:0] mode0_mask;
   wire [7:0] whole_mask;
   wire [7:0] bit_sel;
   wire [7:0] status_word;
   wire full_b;
   wire req_b;
   wire full_a_in;
   wire req_a_in;
   wire full_a_out;
   wire req_a_out;
   wire [`PCS_IRQ_WIDTH-1:0] irq_status;
   wire [`PCS_IRQ_WIDTH-1:0] irq_mask;
   wire [`PCS_IRQ_WIDTH-1:0] irq_events;
   wire strobe_b_n;
   wire strobe_a_in_n;
   wire accept_a_out_n;

   assign a_mode = mode[`PCS_MODE_A_MSB:`PCS_MODE_A_LSB];
   assign a_dir_in = mode[`PCS_MODE_A_DIR_IN];
   assign upper_in = mode[`PCS_MODE_UPPER_IN];
   assign b_mode = mode[`PCS_MODE_B];
   assign b_dir_in = mode[`PCS_MODE_B_DIR_IN];
   assign lower_in = mode[`PCS_MODE_LOWER_IN];
   assign a_in_act = a_in_side(a_mode, a_dir_in);
   assign a_out_act = a_out_side(a_mode, a_dir_in);

   // Bus handshake: every access waits one cycle, so read data come from a flop
   assign request = avs_read | avs_write;
   assign avs_waitrequest = request & ~ack;
   assign accept = request & ack;
   assign lane0 = avs_byteenable[0];
   assign wr_mode = accept & avs_write & lane0 && avs_address == `PCS_OFS_MODE;
   assign wr_portc = accept & avs_write & lane0 && avs_address == `PCS_OFS_PORTC;
   assign wr_bitcmd = accept & avs_write & lane0 && avs_address == `PCS_OFS_BITCMD;
   assign wr_status = accept & avs_write & lane0 && avs_address == `PCS_OFS_IRQ_STATUS;
   assign wr_mask = accept & avs_write & lane0 && avs_address == `PCS_OFS_IRQ_MASK;
   // Port data paths live elsewhere; these strobes stand for their host accesses
   assign acc_a = accept && avs_address == `PCS_OFS_PORTA_STROBE &&
                  (a_in_act & avs_read | a_out_act & avs_write);
   assign acc_b = accept && avs_address == `PCS_OFS_PORTB_STROBE &&
                  (b_dir_in ? avs_read : avs_write);
   assign bit_idx = avs_writedata[`PCS_BITCMD_IDX_MSB:`PCS_BITCMD_IDX_LSB];
   assign bit_val = avs_writedata[`PCS_BITCMD_VALUE];
   assign bit_sel = wr_bitcmd ? (8'h01 << bit_idx) : 8'h00;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         ack <= 1'b0;
      else
         ack <= request & ~ack;
   end

   // Lines claimed by the handshake of each active group
   always @* begin
      hs_in_mask = 8'h00;
      hs_out_mask = 8'h00;
      hs_out_value = 8'h00;
      if (b_mode) begin
         hs_in_mask[`PCS_PC_STROBE_B] = 1'b1;
         hs_out_mask[`PCS_PC_REQ_B] = 1'b1;
         hs_out_mask[`PCS_PC_FULL_B] = 1'b1;
      end
      if (a_in_act | a_out_act)
         hs_out_mask[`PCS_PC_REQ_A] = 1'b1;
      if (a_in_act) begin
         hs_in_mask[`PCS_PC_STROBE_A_IN] = 1'b1;
         hs_out_mask[`PCS_PC_FULL_A_IN] = 1'b1;
      end
      if (a_out_act) begin
         hs_in_mask[`PCS_PC_ACCEPT_A_OUT] = 1'b1;
         hs_out_mask[`PCS_PC_FULL_A_OUT] = 1'b1;
      end
      hs_out_value[`PCS_PC_REQ_B] = req_b;
      // Output side shows an active-low full line
      hs_out_value[`PCS_PC_FULL_B] = b_dir_in ? full_b : ~full_b;
      hs_out_value[`PCS_PC_REQ_A] = req_a_in | req_a_out;
      hs_out_value[`PCS_PC_FULL_A_IN] = full_a_in;
      hs_out_value[`PCS_PC_FULL_A_OUT] = ~full_a_out;
   end

   assign plain_mask = ~(hs_in_mask | hs_out_mask);
   assign out_dir_mask = plain_mask & {{4{~upper_in}}, {4{~lower_in}}};
   assign mode0_mask = {{4{a_mode == 2'h0}}, {4{~b_mode}}};
   assign whole_mask = out_dir_mask & mode0_mask;

   // A pin still driven by the device right after a mode change is no peripheral strobe
   assign strobe_b_n = portc_in[`PCS_PC_STROBE_B] | ~portc_oe_n[`PCS_PC_STROBE_B];
   assign strobe_a_in_n = portc_in[`PCS_PC_STROBE_A_IN] | ~portc_oe_n[`PCS_PC_STROBE_A_IN];
   assign accept_a_out_n = portc_in[`PCS_PC_ACCEPT_A_OUT] | ~portc_oe_n[`PCS_PC_ACCEPT_A_OUT];

   // Mode word and output latches
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode <= `PCS_MODE_RESET;
         latch <= `PCS_PORTC_RESET;
      end else if (wr_mode) begin
         // A new mode word starts from cleared latches
         mode <= avs_writedata[`PCS_MODE_WIDTH-1:0];
         latch <= `PCS_PORTC_RESET;
      end else if (wr_portc) begin
         latch <= (latch & ~whole_mask) | (avs_writedata[7:0] & whole_mask);
      end else if (wr_bitcmd) begin
         // Only plain output lines keep a latch; inputs stay untouched
         if (|(bit_sel & out_dir_mask))
            latch[bit_idx] <= bit_val;
      end
   end

   // Enable flags, set only through the bit command; reset and a mode write clear them
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         group_b_irq_enable <= 1'b0;
         group_a_in_irq_enable <= 1'b0;
         group_a_out_irq_enable <= 1'b0;
      end else if (wr_mode) begin
         group_b_irq_enable <= 1'b0;
         group_a_in_irq_enable <= 1'b0;
         group_a_out_irq_enable <= 1'b0;
      end else if (wr_bitcmd) begin
         // Whole-port writes never reach this branch
         if (bit_sel[`PCS_PC_STROBE_B] & b_mode)
            group_b_irq_enable <= bit_val;
         if (bit_sel[`PCS_PC_STROBE_A_IN] & a_in_act)
            group_a_in_irq_enable <= bit_val;
         if (bit_sel[`PCS_PC_ACCEPT_A_OUT] & a_out_act)
            group_a_out_irq_enable <= bit_val;
      end
   end

   // Handshake channels; a bit command on a status output forces its flop
   pcs_handshake u_hs_b (
      .clk(clk),
      .reset_n(reset_n),
      .enable(b_mode),
      .dir_in(b_dir_in),
      .irq_enable_flag(group_b_irq_enable),
      .strobe_n(strobe_b_n),
      .host_access(acc_b),
      .force_full(bit_sel[`PCS_PC_FULL_B]),
      .full_value(b_dir_in ? bit_val : ~bit_val),
      .force_req(bit_sel[`PCS_PC_REQ_B]),
      .req_value(bit_val),
      .buffer_full(full_b),
      .service_request(req_b)
   );

   pcs_handshake u_hs_a_in (
      .clk(clk),
      .reset_n(reset_n),
      .enable(a_in_act),
      .dir_in(1'b1),
      .irq_enable_flag(group_a_in_irq_enable),
      .strobe_n(strobe_a_in_n),
      .host_access(acc_a & avs_read),
      .force_full(bit_sel[`PCS_PC_FULL_A_IN]),
      .full_value(bit_val),
      .force_req(bit_sel[`PCS_PC_REQ_A]),
      .req_value(bit_val),
      .buffer_full(full_a_in),
      .service_request(req_a_in)
   );

   pcs_handshake u_hs_a_out (
      .clk(clk),
      .reset_n(reset_n),
      .enable(a_out_act),
      .dir_in(1'b0),
      .irq_enable_flag(group_a_out_irq_enable),
      .strobe_n(accept_a_out_n),
      .host_access(acc_a & avs_write),
      .force_full(bit_sel[`PCS_PC_FULL_A_OUT]),
      .full_value(~bit_val),
      // Mode 2 shares one request pin, so the bit command drives both sides
      .force_req(bit_sel[`PCS_PC_REQ_A]),
      .req_value(bit_val),
      .buffer_full(full_a_out),
      .service_request(req_a_out)
   );

   // Pin drive, registered so the pins never glitch on decode
   always @* begin
      next_portc_out = (latch & out_dir_mask) | (hs_out_value & hs_out_mask);
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         portc_out <= `PCS_PORTC_RESET;
         portc_oe_n <= 8'hff;
      end else begin
         portc_out <= next_portc_out;
         portc_oe_n <= ~(out_dir_mask | hs_out_mask);
      end
   end

   // Status read: live pins with the enable flags over the strobe positions
   assign status_word = {portc_in[7],
                         hs_in_mask[`PCS_PC_ACCEPT_A_OUT] ? group_a_out_irq_enable : portc_in[6],
                         portc_in[5],
                         hs_in_mask[`PCS_PC_STROBE_A_IN] ? group_a_in_irq_enable : portc_in[4],
                         portc_in[3],
                         hs_in_mask[`PCS_PC_STROBE_B] ? group_b_irq_enable : portc_in[2],
                         portc_in[1:0]};

   always @* begin
      next_readdata = 32'h0000_0000;
      case (avs_address)
         `PCS_OFS_MODE: next_readdata[`PCS_MODE_WIDTH-1:0] = mode;
         `PCS_OFS_PORTC: next_readdata[7:0] = status_word;
         `PCS_OFS_IRQ_STATUS: next_readdata[`PCS_IRQ_WIDTH-1:0] = irq_status;
         `PCS_OFS_IRQ_MASK: next_readdata[`PCS_IRQ_WIDTH-1:0] = irq_mask;
         default: next_readdata = 32'h0000_0000;
      endcase
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read & ~ack)
         avs_readdata <= next_readdata;
   end

   // Interrupt events are rising edges of the two service requests
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         req_a_prev <= 1'b0;
         req_b_prev <= 1'b0;
      end else begin
         req_a_prev <= req_a_in | req_a_out;
         req_b_prev <= req_b;
      end
   end

   // Edge events keep a request that stays high from setting a cleared bit again
   assign irq_events = {req_b & ~req_b_prev, (req_a_in | req_a_out) & ~req_a_prev};

   pcs_irq_ctrl #(
      .WIDTH(`PCS_IRQ_WIDTH)
   ) u_irq (
      .clk(clk),
      .reset_n(reset_n),
      .event_pulse(irq_events),
      .status_write(wr_status),
      .mask_write(wr_mask),
      .write_data(avs_writedata[`PCS_IRQ_WIDTH-1:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(irq)
   );
endmodule
`default_nettype wire

// file: tb/pcs_periph.sv
// Peripheral side of port C: each wire resolved from device or peripheral drive
`default_nettype none
module pcs_periph (
   // Device pin drive
   input wire logic [7:0] portc_out,
   input wire logic [7:0] portc_oe_n,
   // Peripheral strobe, accept and data levels
   input wire logic [7:0] periph_drive,
   // Resolved wire levels
   output wire logic [7:0] portc_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Driven lines show the device value, released lines the peripheral value
   assign portc_in = (portc_out & ~portc_oe_n) | (periph_drive & portc_oe_n);
endmodule
`default_nettype wire

// file: tb/pcs_portc_props.sv
// Bus and pin checks for the port C block
`default_nettype none
`include "pcs_regs.vh"
module pcs_portc_props (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register bus
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Pins
   input wire logic [7:0] portc_in,
   input wire logic [7:0] portc_out,
   input wire logic [7:0] portc_oe_n,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire logic mode_acc = avs_write && !avs_waitrequest && avs_address == `PCS_OFS_MODE
      && avs_byteenable[0];
   sequence s_wr(logic [4:0] a);
      avs_write && !avs_waitrequest && avs_address == a && avs_byteenable[0];
   endsequence
   sequence s_rd(logic [4:0] a);
      avs_read && !avs_waitrequest && avs_address == a;
   endsequence
   property p_wait_first;
      $rose(avs_read || avs_write) |-> avs_waitrequest;
   endproperty
   property p_wait_one;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   property p_reset_clean;
      $rose(reset_n) |-> portc_out == 8'h00 && !irq;
   endproperty
   property p_whole_write;
      s_wr(`PCS_OFS_PORTC) ##0 portc_oe_n == 8'h00
         |-> ##2 portc_out == $past(avs_writedata[7:0], 2);
   endproperty
   // Direction only moves after a mode write; the release of reset is exempt
   property p_oe_mode;
      $changed(portc_oe_n) && $past(reset_n, 2) |-> $past(mode_acc) || $past(mode_acc, 2);
   endproperty
   property p_bit_dir;
      s_wr(`PCS_OFS_BITCMD) |=> $stable(portc_oe_n) [*2];
   endproperty
   property p_read_pins;
      s_rd(`PCS_OFS_PORTC) ##0 portc_oe_n == 8'h00 ##0 $stable(portc_in)
         |-> avs_readdata[7:0] == portc_in;
   endproperty
   property p_read_pad;
      avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
   endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait state");
   a_wait_one: assert property (p_wait_one) else $error("wait too long");
   a_reset_clean: assert property (p_reset_clean) else $error("reset state");
   a_whole_write: assert property (p_whole_write) else $error("port write");
   a_oe_mode: assert property (p_oe_mode) else $error("direction moved");
   a_bit_dir: assert property (p_bit_dir) else $error("bit cmd direction");
   a_read_pins: assert property (p_read_pins) else $error("pin read");
   a_read_pad: assert property (p_read_pad) else $error("upper read bits");
endmodule
bind pcs_portc pcs_portc_props u_props (.clk(clk), .reset_n(reset_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .portc_in(portc_in), .portc_out(portc_out), .portc_oe_n(portc_oe_n), .irq(irq));
`default_nettype wire

// file: tb/pcs_portc_tb.sv
// Self-checking bench for the port C block
`default_nettype none
`include "pcs_regs.vh"
module pcs_portc_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [7:0] ext = 8'hff;
   logic [31:0] q;
   wire logic [31:0] avs_readdata;
   wire logic avs_waitrequest;
   wire logic irq;
   wire logic [7:0] portc_in;
   wire logic [7:0] portc_out;
   wire logic [7:0] portc_oe_n;
   integer n_mismatch = 0;
   integer checks = 0;
   always #5 clk = ~clk;
   pcs_portc dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .portc_in(portc_in), .portc_out(portc_out),
      .portc_oe_n(portc_oe_n), .irq(irq));
   pcs_periph u_periph (.portc_out(portc_out), .portc_oe_n(portc_oe_n),
      .periph_drive(ext), .portc_in(portc_in));
   task summarize;
      begin
         $display("checks %0d mismatches %0d", checks, n_mismatch);
         if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      begin
         checks++;
         if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", nm, e, s);
         end
      end
   endtask
   // Request held until waitrequest is sampled low, released at that edge
   task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      integer k;
      begin
         @(posedge clk);
         avs_address <= a;
         avs_writedata <= {24'h0, d};
         avs_write <= w;
         avs_read <= !w;
         k = 0;
         do begin
            @(posedge clk);
            k++;
         end while (avs_waitrequest !== 1'b0 && k < 50);
         q = avs_readdata;
         avs_write <= 1'b0;
         avs_read <= 1'b0;
         if (k >= 50) begin
            n_mismatch++;
            summarize;
         end
      end
   endtask
   task wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task rd(input logic [4:0] a);
      bus(1'b0, a, 8'h00);
   endtask
   // Pins settle one edge after the latch edge
   task pause(input integer k);
      begin
         repeat (k) @(posedge clk);
         #1;
      end
   endtask
   task drv(input logic [7:0] v);
      begin
         @(posedge clk);
         ext <= v;
      end
   endtask
   initial begin
      repeat (6) @(posedge clk);
      chk("oe_rst", 8'hff, portc_oe_n);
      reset_n <= 1'b1;
      pause(2);
      chk("out_rst", 8'h00, portc_out);
      chk("oe_m0", 8'h00, portc_oe_n);
      wr(`PCS_OFS_PORTC, 8'ha5);
      pause(1);
      chk("out_wr", 8'ha5, portc_out);
      rd(`PCS_OFS_PORTC);
      chk("rd_pins", 8'ha5, q[7:0]);
      avs_byteenable <= 4'h0;
      wr(`PCS_OFS_PORTC, 8'h00);
      avs_byteenable <= 4'hf;
      wr(`PCS_OFS_BITCMD, 8'h09);
      wr(`PCS_OFS_BITCMD, 8'h07);
      pause(1);
      chk("bit_out", 8'h27, portc_out);
      rd(5'h1c);
      chk("unmapped", 8'h00, q[7:0]);
      // Upper lines as inputs, peripheral drives them
      drv(8'h50);
      wr(`PCS_OFS_MODE, 8'h08);
      wr(`PCS_OFS_PORTC, 8'hff);
      wr(`PCS_OFS_BITCMD, 8'h0e);
      pause(1);
      chk("oe_up_in", 8'hf0, portc_oe_n);
      chk("out_low", 8'h0f, portc_out & 8'h0f);
      rd(`PCS_OFS_PORTC);
      chk("rd_mix", 8'h5f, q[7:0]);
      // Group B strobed output; bit 3 sits in group B, so whole writes skip it
      drv(8'hff);
      wr(`PCS_OFS_MODE, 8'h10);
      wr(`PCS_OFS_PORTB_STROBE, 8'h00);
      wr(`PCS_OFS_PORTC, 8'hff);
      rd(`PCS_OFS_PORTC);
      chk("b_full", 8'hf0, q[7:0]);
      wr(`PCS_OFS_BITCMD, 8'h0a);
      rd(`PCS_OFS_PORTC);
      chk("b_flag", 8'hf4, q[7:0]);
      wr(`PCS_OFS_IRQ_MASK, 8'h02);
      drv(8'hfb);
      drv(8'hff);
      pause(4);
      chk("b_req", 8'h03, portc_out & 8'h03);
      chk("irq_b", 8'h01, {7'h0, irq});
      wr(`PCS_OFS_IRQ_MASK, 8'h00);
      pause(1);
      chk("irq_mask", 8'h00, {7'h0, irq});
      rd(`PCS_OFS_IRQ_STATUS);
      chk("sts", 8'h02, q[7:0]);
      wr(`PCS_OFS_IRQ_STATUS, 8'h02);
      wr(`PCS_OFS_IRQ_MASK, 8'h02);
      pause(1);
      chk("irq_clr", 8'h00, {7'h0, irq});
      wr(`PCS_OFS_PORTB_STROBE, 8'h00);
      pause(2);
      chk("b_wr", 8'h00, portc_out & 8'h03);
      // Group A strobed input
      wr(`PCS_OFS_MODE, 8'h05);
      wr(`PCS_OFS_BITCMD, 8'h0c);
      wr(`PCS_OFS_IRQ_MASK, 8'h01);
      drv(8'hef);
      drv(8'hff);
      pause(4);
      chk("a_full", 8'h28, portc_out & 8'h28);
      chk("irq_a", 8'h01, {7'h0, irq});
      rd(`PCS_OFS_PORTC);
      chk("a_flag", 8'h10, q[7:0] & 8'h10);
      rd(`PCS_OFS_PORTA_STROBE);
      pause(2);
      chk("a_clr", 8'h00, portc_out & 8'h28);
      // Group A bidirectional
      wr(`PCS_OFS_MODE, 8'h02);
      wr(`PCS_OFS_BITCMD, 8'h0e);
      rd(`PCS_OFS_PORTC);
      chk("a2_on", 8'h40, q[7:0] & 8'h40);
      wr(`PCS_OFS_BITCMD, 8'h06);
      wr(`PCS_OFS_BITCMD, 8'h07);
      pause(1);
      chk("a2_full", 8'h00, portc_out & 8'h80);
      rd(`PCS_OFS_PORTC);
      chk("a2_off", 8'h00, q[7:0] & 8'h40);
      // Reset in mid-run: latches, mode and interrupt state return to rest
      wr(`PCS_OFS_PORTC, 8'hff);
      pause(1);
      chk("a2_plain", 8'h07, portc_out & 8'h07);
      rd(`PCS_OFS_IRQ_STATUS);
      chk("sts_a", 8'h01, q[7:0]);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      pause(2);
      chk("out_rst2", 8'h00, portc_out);
      chk("irq_rst2", 8'h00, {7'h0, irq});
      rd(`PCS_OFS_MODE);
      chk("mode_rst2", 8'h00, q[7:0]);
      rd(`PCS_OFS_IRQ_STATUS);
      chk("sts_rst2", 8'h00, q[7:0]);
      summarize;
   end
endmodule
`default_nettype wire
